// [rtl/pci_power_state_manager.sv]
// PCI power management capability registers and power state machine
// Function
// - Two capability words at config offsets 0x40 and 0x44
// - Wake support field reads 01000b
// - Wake clock bit reads one
// - Reserved zero, version 010b, next 00, ID 01
// - Data and bridge fields read zero
// - Status bit15, enable bit8, state bits1:0
// - Only D0 and D3hot supported
// - Uninitialized after reset, active once initialized
// - D0 active accepts all, interrupts allowed
// - D3hot: config only, no memory, no interrupt
// - Channels keep receiving in D3hot
// - Receive start bit wakes when enabled
// - Modem delta flag wakes when enabled
// - Status flag set regardless of enable
// - Status cleared only by writing one
// - D3hot to D0 goes active, keeps context
// - Output drivers off during D3hot to D0 uninit; the phase machine never takes that path, so pci_drive_en stays high
// - Context preserved in D3hot
// - Sleep mode independent of power state
// - Reset returns everything to defaults
`timescale 1ns/1ns
`include "pm_regs.svh"
module pci_power_state_manager
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [3:0] cfg_be,
    output logic [31:0] cfg_rdata,
    output logic cfg_hit,
    input wire logic sw_init_done,
    input wire logic mem_req,
    output logic mem_accept,
    input wire logic uart_irq,
    output logic inta_out,
    output logic pci_drive_en,
    input wire logic [`PM_CHANNELS-1:0] rx_pin,
    input wire logic [`PM_CHANNELS*`PM_DELTA_W-1:0] modem_input_status,
    input wire logic sleep_request,
    output logic sleep_allow,
    output logic rx_enable,
    output logic wake_event_n,
    output logic [1:0] power_phase
);
    import pm_pkg::*;

    power_phase_t phase_reg;
    power_phase_t phase_next;
    logic wake_status_flag_reg;
    logic wake_enable_bit_reg;
    logic [1:0] power_state_field_reg;
    logic [1:0] power_state_field_next;
    logic [31:0] rdata_reg;
    logic hit_reg;
    logic pme_reg;
    logic [`PM_CHANNELS-1:0] chan_event;
    wire any_event;
    wire sel_cap;
    wire sel_csr;
    wire csr_wr;
    wire low_wr;
    wire high_wr;
    wire state_ok;
    wire [31:0] cap_word;
    wire [31:0] csr_word;
    wire in_d3;

    // Two capability words sitting at their configuration offsets
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        addr_is = (a[7:2] == off[7:2]);
    endfunction

    //--------------------------------------------------------------
    // Wake event detection per channel
    //--------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < `PM_CHANNELS; ch = ch + 1)
        begin : g_chan
            wake_detect u_det
            (
                .clk(clk),
                .rst_n(rst_n),
                .rx_pin(rx_pin[ch]),
                .modem_delta(modem_input_status[ch*`PM_DELTA_W +: `PM_DELTA_W]),
                .event_pulse(chan_event[ch])
            );
        end
    endgenerate

    //--------------------------------------------------------------
    // Decode
    //--------------------------------------------------------------
    // capability decode
    assign sel_cap = addr_is(cfg_addr, `PM_CAP_OFFSET);
    assign sel_csr = addr_is(cfg_addr, `PM_CSR_OFFSET);
    assign csr_wr = cfg_wr & sel_csr;
    assign low_wr = csr_wr & cfg_be[0];
    assign high_wr = csr_wr & cfg_be[1];
    assign in_d3 = (phase_reg == D3_HOT);
    // start bit events only count in D3hot
    assign any_event = in_d3 & (|chan_event);

    // support field, clock bit, fixed fields
    assign cap_word = {`PM_CAP_SUPPORT, 7'h00, `PM_CAP_CLOCK, `PM_CAP_VERSION, `PM_CAP_NEXT, `PM_CAP_ID};
    // data and bridge zero; status layout
    assign csr_word = {16'h0000, wake_status_flag_reg, 6'h00, wake_enable_bit_reg, 6'h00, power_state_field_reg};

    // only D0 and D3hot encodings are accepted
    assign state_ok = (cfg_wdata[1:0] == `PM_STATE_D0) | (cfg_wdata[1:0] == `PM_STATE_D3HOT);

    //--------------------------------------------------------------
    // Power state field and phase machine
    //--------------------------------------------------------------
    // Next state field value on writes
    always_comb
    begin
        power_state_field_next = power_state_field_reg;
        if (low_wr && state_ok)
        begin
            power_state_field_next = cfg_wdata[1:0];
        end
    end

    // three phases; uninit then active; D3 back to active
    always_comb
    begin
        phase_next = phase_reg;
        case (phase_reg)
            D0_UNINIT:
            begin
                if (power_state_field_next == `PM_STATE_D3HOT)
                begin
                    phase_next = D3_HOT;
                end
                else if (sw_init_done)
                begin
                    phase_next = D0_ACTIVE;
                end
            end
            D0_ACTIVE:
            begin
                if (power_state_field_next == `PM_STATE_D3HOT)
                begin
                    phase_next = D3_HOT;
                end
            end
            D3_HOT:
            begin
                if (power_state_field_next == `PM_STATE_D0)
                begin
                    phase_next = D0_ACTIVE;
                end
            end
            default:
            begin
                phase_next = D0_UNINIT;
            end
        endcase
    end

    // synchronous reset restores defaults; no other path clears context
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            phase_reg <= D0_UNINIT;
            power_state_field_reg <= `PM_STATE_D0;
            wake_enable_bit_reg <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            power_state_field_reg <= power_state_field_next;
            if (high_wr)
            begin
                wake_enable_bit_reg <= cfg_wdata[`PM_ENABLE_BIT];
            end
        end
    end

    //--------------------------------------------------------------
    // Wake status and wake output
    //--------------------------------------------------------------
    // set on event regardless of enable; write one clears, set wins
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wake_status_flag_reg <= 1'b0;
            pme_reg <= 1'b0;
        end
        else
        begin
            if (any_event)
            begin
                wake_status_flag_reg <= 1'b1;
            end
            else if (high_wr && cfg_wdata[`PM_STATUS_BIT])
            begin
                wake_status_flag_reg <= 1'b0;
            end
            // wake output follows enabled status while in D3hot
            pme_reg <= in_d3 & wake_enable_bit_reg & (wake_status_flag_reg | any_event);
        end
    end
    assign wake_event_n = ~pme_reg;

    //--------------------------------------------------------------
    // Configuration read path
    //--------------------------------------------------------------
    // Registered read data; unmapped offsets return zero without hit
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rdata_reg <= 32'h0000_0000;
            hit_reg <= 1'b0;
        end
        else
        begin
            hit_reg <= (cfg_rd | cfg_wr) & (sel_cap | sel_csr);
            rdata_reg <= !cfg_rd ? 32'h0000_0000 : sel_cap ? cap_word : sel_csr ? csr_word : 32'h0000_0000;
        end
    end
    assign cfg_rdata = rdata_reg;
    assign cfg_hit = hit_reg;

    //--------------------------------------------------------------
    // Function gating by phase
    //--------------------------------------------------------------
    // active accepts memory and raises interrupts; D3hot blocks both
    assign mem_accept = mem_req & (phase_reg == D0_ACTIVE);
    assign inta_out = uart_irq & (phase_reg == D0_ACTIVE);
    // drivers drop only on a D3hot to D0 uninitialized step, which phase_next never takes, so they stay on
    assign pci_drive_en = ~(in_d3 & (phase_next == D0_UNINIT));
    // receivers stay on in every phase
    assign rx_enable = 1'b1;
    // sleep allowed in any phase; software avoids it in D3hot
    assign sleep_allow = sleep_request;
    assign power_phase = phase_reg;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    sequence s_event_in_d3;
        in_d3 && (|chan_event);
    endsequence

    a_cap_word_const: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_rd && sel_cap) |=> (cfg_rdata == 32'h400a_0001))
        else $error("capability word wrong");
    a_status_sets: assert property (@(posedge clk) disable iff (!rst_n)
        s_event_in_d3 |=> wake_status_flag_reg)
        else $error("status not set by event");
    a_status_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (high_wr && cfg_wdata[15] && !any_event) |=> !wake_status_flag_reg)
        else $error("status not cleared");
    a_status_keep: assert property (@(posedge clk) disable iff (!rst_n)
        (wake_status_flag_reg && !(high_wr && cfg_wdata[15])) |=> wake_status_flag_reg)
        else $error("status lost");
    a_wake_enabled: assert property (@(posedge clk) disable iff (!rst_n)
        (s_event_in_d3 ##0 wake_enable_bit_reg) |=> !wake_event_n)
        else $error("wake not asserted");
    a_wake_off_d0: assert property (@(posedge clk) disable iff (!rst_n)
        ($past(!in_d3) || $past(!wake_enable_bit_reg)) |-> wake_event_n)
        else $error("wake outside D3hot");
    a_d3_no_irq: assert property (@(posedge clk) disable iff (!rst_n)
        in_d3 |-> (!inta_out && !mem_accept))
        else $error("activity in D3hot");
    a_d3_to_active: assert property (@(posedge clk) disable iff (!rst_n)
        (in_d3 && low_wr && cfg_wdata[1:0] == 2'h0) |=> (phase_reg == D0_ACTIVE))
        else $error("D3hot exit wrong");
    a_bad_state: assert property (@(posedge clk) disable iff (!rst_n)
        (low_wr && !state_ok) |=> $stable(power_state_field_reg))
        else $error("bad encoding accepted");
    a_csr_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_rd && sel_csr) |=> (cfg_rdata[31:16] == 16'h0000 && cfg_rdata[14:9] == 6'h00))
        else $error("csr reserved bits set");
endmodule

// [rtl/pm_regs.svh]
// Constants for the power management capability block
`ifndef PM_REGS_SVH
`define PM_REGS_SVH
`define PM_CAP_OFFSET 8'h40
`define PM_CSR_OFFSET 8'h44
`define PM_CAP_SUPPORT 5'h08
`define PM_CAP_CLOCK 1'h1
`define PM_CAP_VERSION 3'h2
`define PM_CAP_NEXT 8'h00
`define PM_CAP_ID 8'h01
`define PM_STATUS_BIT 15
`define PM_ENABLE_BIT 8
`define PM_STATE_D0 2'h0
`define PM_STATE_D3HOT 2'h3
`define PM_CHANNELS 2
`define PM_DELTA_W 4
`define PM_SLEEP_SETTLE_MS 20
`endif

// [rtl/pm_pkg.sv]
// Types for the power management capability block
package pm_pkg;
    typedef enum logic [1:0] {
        D0_UNINIT,
        D0_ACTIVE,
        D3_HOT
    } power_phase_t;
endpackage

// [rtl/wake_detect.sv]
// Per-channel wake event detector: synchronised receive start bit or modem delta
`timescale 1ns/1ns
`include "pm_regs.svh"
module wake_detect
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rx_pin,
    input wire logic [3:0] modem_delta,
    output logic event_pulse
);
    logic rx_meta_reg;
    logic rx_sync_reg;
    logic rx_prev_reg;
    logic [3:0] delta_prev_reg;
    logic event_pulse_reg;
    wire fall_seen;
    wire delta_rise;

    // Start bit is a falling edge; a delta flag counts as it becomes set
    assign fall_seen = rx_prev_reg & ~rx_sync_reg;
    assign delta_rise = |(modem_delta & ~delta_prev_reg);
    assign event_pulse = event_pulse_reg;

    // Two-stage synchroniser, then edge history
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
            delta_prev_reg <= 4'h0;
            event_pulse_reg <= 1'b0;
        end
        else
        begin
            rx_meta_reg <= rx_pin;
            rx_sync_reg <= rx_meta_reg;
            rx_prev_reg <= rx_sync_reg;
            delta_prev_reg <= modem_delta;
            event_pulse_reg <= fall_seen | delta_rise;
        end
    end
endmodule

// [tb/pci_host_model.sv]
// Host bridge model that issues configuration cycles
`timescale 1ns/1ns
module pci_host_model
(
    input wire logic clk,
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [7:0] cfg_addr,
    output logic [31:0] cfg_wdata,
    output logic [3:0] cfg_be
);
    initial
    begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_wdata = 32'h0;
        cfg_be = 4'h0;
    end
    // Released bus shows inverted address and data, not stale ones
    task automatic release_bus();
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = ~cfg_addr;
        cfg_wdata = ~cfg_wdata;
    endtask
    // software clears status by writing one
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        cfg_be = b;
        @(negedge clk);
        release_bus();
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge clk);
        release_bus();
    endtask
endmodule

// [tb/pci_power_state_manager_bench.sv]
// Self-checking bench for the power management block
`timescale 1ns/1ns
`include "pm_regs.svh"
module pci_power_state_manager_bench;
    import pm_pkg::*;
    logic clk, rst_n, cfg_wr, cfg_rd, cfg_hit, sw_init_done, mem_req, mem_accept, uart_irq, inta_out;
    logic pci_drive_en, sleep_request, sleep_allow, rx_enable, wake_event_n, rd_q;
    logic [7:0] cfg_addr, modem;
    logic [31:0] cfg_wdata, cfg_rdata, cap;
    logic [3:0] cfg_be;
    logic [1:0] rx_pin, power_phase;
    logic [32:0] exp_q[$];
    int err_count, compares;
    pci_host_model host (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_be(cfg_be));
    pci_power_state_manager dut (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_rdata(cfg_rdata),
        .cfg_hit(cfg_hit), .sw_init_done(sw_init_done), .mem_req(mem_req), .mem_accept(mem_accept),
        .uart_irq(uart_irq), .inta_out(inta_out), .pci_drive_en(pci_drive_en), .rx_pin(rx_pin),
        .modem_input_status(modem), .sleep_request(sleep_request), .sleep_allow(sleep_allow),
        .rx_enable(rx_enable), .wake_event_n(wake_event_n), .power_phase(power_phase));
    assign cap = {`PM_CAP_SUPPORT, 7'h00, `PM_CAP_CLOCK, `PM_CAP_VERSION, `PM_CAP_NEXT, `PM_CAP_ID};
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Compare one value and count it
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Note the answer expected one cycle after a read
    task automatic rd(input logic [7:0] a, input logic hit, input logic [31:0] d);
        exp_q.push_back({hit, d});
        host.rd(a);
    endtask
    // Read monitor: pop the oldest note when an answer stands
    always @(posedge clk) rd_q <= cfg_rd;
    always @(negedge clk)
    begin
        if (rd_q)
        begin
            if (exp_q.size() == 0)
                check("read_queue", 33'h1, 33'h0);
            else
                check("cfg_read", {cfg_hit, cfg_rdata}, exp_q.pop_front());
        end
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Apply reset for eight cycles
    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'b0;
        wait_n(8);
        rst_n = 1'b1;
    endtask
    // Raise one wake cause, check flag and wake output
    task automatic wake(input bit use_rx, input logic en);
        int k;
        k = $urandom % 8;
        @(negedge clk);
        if (use_rx)
            rx_pin[k % 2] = 1'b0;
        else
            modem = 8'h01 << k;
        @(negedge clk);
        modem = 8'h00;
        wait_n(5);
        rx_pin = 2'b11;
        check("wake_n", wake_event_n, !en);
        rd(8'h44, 1'b1, {16'h0, 8'h80 | en, 8'h03});
        host.wr(8'h44, {16'h0, 8'h00 | en, 8'h03}, 4'h3);
        rd(8'h44, 1'b1, {16'h0, 8'h80 | en, 8'h03});
        host.wr(8'h44, {16'h0, 8'h80 | en, 8'h03}, 4'h3);
        rd(8'h44, 1'b1, {16'h0, 7'h0, en, 8'h03});
        wait_n(1);
        check("wake_clear", wake_event_n, 1'b1);
    endtask
    task automatic wrap_up();
        wait_n(2);
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #(40 * 4000);
        err_count++;
        wrap_up();
    end
    initial
    begin
        rst_n = 1'b0;
        sw_init_done = 1'b0;
        mem_req = 1'b0;
        uart_irq = 1'b0;
        rx_pin = 2'b11;
        modem = 8'h00;
        sleep_request = 1'b0;
        void'($urandom(68));
        do_reset();
        rd(8'h40, 1'b1, cap);
        rd(8'h44, 1'b1, 32'h0);
        rd(8'h48, 1'b0, 32'h0);
        check("phase_reset", power_phase, D0_UNINIT);
        $display("test reset done");
        sw_init_done = 1'b1;
        mem_req = 1'b1;
        uart_irq = 1'b1;
        wait_n(2);
        check("phase_active", power_phase, D0_ACTIVE);
        check("mem_d0", {mem_accept, inta_out}, 2'b11);
        sleep_request = 1'b1;
        wait_n(1);
        check("sleep_d0", sleep_allow, 1'b1);
        // sleep stays off before entering D3hot
        sleep_request = 1'b0;
        host.wr(8'h44, ($urandom & 32'hffff7efc) | 32'h103, 4'h3);
        rd(8'h44, 1'b1, 32'h103);
        check("phase_d3", power_phase, D3_HOT);
        check("mem_d3", {mem_accept, inta_out}, 2'b00);
        check("rx_on", {rx_enable, pci_drive_en}, 2'b11);
        rd(8'h40, 1'b1, cap);
        $display("test d3hot entry done");
        wake(1'b1, 1'b1);
        wake(1'b0, 1'b1);
        host.wr(8'h44, 32'h003, 4'h3);
        wake(1'b0, 1'b0);
        wake(1'b1, 1'b0);
        $display("test wake done");
        for (int s = 1; s < 3; s++)
        begin
            host.wr(8'h44, s, 4'h1);
            rd(8'h44, 1'b1, 32'h003);
        end
        host.wr(8'h44, 32'h100, 4'h3);
        wait_n(1);
        check("phase_back", power_phase, D0_ACTIVE);
        rd(8'h44, 1'b1, 32'h100);
        $display("test d0 return done");
        // Software must initialise again after a reset, so its done level drops first
        sw_init_done = 1'b0;
        do_reset();
        rd(8'h44, 1'b1, 32'h0);
        check("phase_rst2", power_phase, D0_UNINIT);
        host.wr(8'h44, 32'h003, 4'h1);
        check("phase_uninit_d3", power_phase, D3_HOT);
        $display("test second reset done");
        wrap_up();
    end
endmodule
